/* common/gdc_pkg.sv */
// gdc_pkg: register map, field positions and codes of the dma channel.
// assumes a 32-bit ahb-lite register port and a 24-bit channel bus.
package gdc_pkg;
  // register byte offsets (low address byte)
  localparam logic [7:0] ADDR_MODE  = 8'h00;
  localparam logic [7:0] ADDR_SRC   = 8'h04;
  localparam logic [7:0] ADDR_DST   = 8'h08;
  localparam logic [7:0] ADDR_FC    = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_STAT  = 8'h14;
  // channel_mode fields
  localparam int MODE_RSVD    = 15;
  localparam int MODE_NORMAL_IRQ_ENABLE    = 13;
  localparam int MODE_ERROR_IRQ_ENABLE    = 12;
  localparam int MODE_REQUEST_GENERATION_LO = 10;
  localparam int MODE_SOURCE_INCREMENT    = 9;
  localparam int MODE_DESTINATION_INCREMENT    = 8;
  localparam int MODE_SOURCE_SIZE_LO = 6;
  localparam int MODE_DESTINATION_SIZE_LO = 4;
  localparam int MODE_BT_LO   = 2;
  localparam int MODE_RST     = 1;
  localparam int MODE_STR     = 0;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'h7ffd;
  // channel_status fields
  localparam int STAT_DONE = 0;
  localparam int STAT_BES  = 1;
  localparam int STAT_BED  = 2;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // request generation and operand size codes
  localparam logic [1:0] REQUEST_GENERATION_LIMITED = 2'h0;
  localparam logic [1:0] REQUEST_GENERATION_MAX     = 2'h1;
  localparam logic [1:0] SIZE_BYTE    = 2'h1;
  localparam logic [1:0] SIZE_WORD    = 2'h2;
  // bus cycles allowed per 8-cycle window: 75, 50, 25, 12.5 percent
  localparam logic [3:0] ALLOW_BT0 = 4'h6;
  localparam logic [3:0] ALLOW_BT1 = 4'h4;
  localparam logic [3:0] ALLOW_BT2 = 4'h2;
  localparam logic [3:0] ALLOW_BT3 = 4'h1;
  localparam logic [2:0] WIN_LAST  = 3'h7;
  // channel sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } gdc_state_e;
endpackage

/* verilog/gdc_channel.sv */
// gdc_channel: one memory-to-memory dma channel with ahb-lite registers.
// assumes the channel bus answers each request with an ack or berr pulse
// on hclk, and that the watchdog error arrives as that berr pulse.
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module gdc_channel
  import gdc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             dma_req,
  output logic             dma_write,
  output logic             dma_word,
  output logic [23:0]      dma_addr,
  output logic [2:0]       dma_fc,
  output logic [15:0]      dma_wdata,
  input  wire logic [15:0] dma_rdata,
  input  wire logic        dma_ack,
  input  wire logic        dma_berr,
  output logic             irq
);

  // word operand when the size code says so
  function automatic logic size_word(input logic [1:0] code);
    size_word = (code == SIZE_WORD);
  endfunction

  gdc_state_e  state_reg;
  gdc_state_e  state_next;
  logic [15:0] mode_reg;
  logic [23:0] src_reg;
  logic [23:0] dst_reg;
  logic [7:0]  fc_reg;
  logic [15:0] count_reg;
  logic [7:0]  status_reg;
  logic [7:0]  status_next;
  logic [15:0] data_reg;
  logic [23:0] addr_reg;
  logic        word_reg;
  logic        moved_reg;
  logic [2:0]  win_reg;
  logic [7:0]  used_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] hrdata_reg;

  wire        acc_w;
  wire [31:0] rd_mux_w;
  wire        wr_mode_w;
  wire        wr_src_w;
  wire        wr_dst_w;
  wire        wr_fc_w;
  wire        wr_count_w;
  wire        wr_stat_w;
  wire        sw_rst_w;
  wire [1:0]  request_generation_w;
  wire [1:0]  bt_w;
  wire [3:0]  allow_w;
  wire        budget_ok_w;
  wire        op_word_w;
  wire [23:0] step24_w;
  wire [15:0] step16_w;
  wire [15:0] count_dec_w;
  wire        last_w;
  wire        finished_w;
  wire        go_w;
  wire        ack_ok_w;
  wire        berr_w;
  wire        bes_ev_w;
  wire        bed_ev_w;
  wire        rd_done_w;
  wire        wr_done_w;
  wire        done_ev_w;
  wire        str_clr_w;
  wire [7:0]  set_w;
  wire [7:0]  clr_w;

  // zero-wait slave; every access answers okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;
  assign acc_w     = hsel && hready && htrans[1];

  // read mux, reserved and unmapped bits read as zero
  // upper source bits read zero
  assign rd_mux_w =
    (haddr[7:0] == ADDR_MODE)  ? {16'h0000, mode_reg} :
    (haddr[7:0] == ADDR_SRC)   ? {8'h00, src_reg} :
    (haddr[7:0] == ADDR_DST)   ? {8'h00, dst_reg} :
    (haddr[7:0] == ADDR_FC)    ? {24'h000000, fc_reg} :
    (haddr[7:0] == ADDR_COUNT) ? {16'h0000, count_reg} :
    (haddr[7:0] == ADDR_STAT)  ? {24'h000000, status_reg} :
    32'h00000000;

  // write decode in the data phase
  assign wr_mode_w  = wr_pend_reg && (wr_addr_reg == ADDR_MODE);
  assign wr_src_w   = wr_pend_reg && (wr_addr_reg == ADDR_SRC);
  assign wr_dst_w   = wr_pend_reg && (wr_addr_reg == ADDR_DST);
  assign wr_fc_w    = wr_pend_reg && (wr_addr_reg == ADDR_FC);
  assign wr_count_w = wr_pend_reg && (wr_addr_reg == ADDR_COUNT);
  assign wr_stat_w  = wr_pend_reg && (wr_addr_reg == ADDR_STAT);
  assign sw_rst_w   = wr_mode_w && hwdata[MODE_RST];

  // address phase capture; read data sampled at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h00000000;
    end else begin
      wr_pend_reg <= acc_w && hwrite;
      if (acc_w) begin
        wr_addr_reg <= haddr[7:0];
      end
      if (acc_w && !hwrite) begin
        hrdata_reg <= rd_mux_w;
      end
    end
  end

  // mode fields and bandwidth budget
  assign request_generation_w = mode_reg[MODE_REQUEST_GENERATION_LO +: 2];
  assign bt_w   = mode_reg[MODE_BT_LO +: 2];
  assign allow_w = (bt_w == 2'h0) ? ALLOW_BT0 :
                   (bt_w == 2'h1) ? ALLOW_BT1 :
                   (bt_w == 2'h2) ? ALLOW_BT2 : ALLOW_BT3;
  // external codes never start a cycle
  assign budget_ok_w = (request_generation_w == REQUEST_GENERATION_MAX) ||
                       ((request_generation_w == REQUEST_GENERATION_LIMITED) && (used_reg < 8'(allow_w)));

  // operand size and pointer steps
  // word only when both sizes say word
  assign op_word_w = size_word(mode_reg[MODE_SOURCE_SIZE_LO +: 2]) &&
                     size_word(mode_reg[MODE_DESTINATION_SIZE_LO +: 2]) &&
                     !src_reg[0] && !dst_reg[0] && (count_reg != 16'h0001);
  assign step24_w  = word_reg ? 24'h000002 : 24'h000001;
  assign step16_w  = word_reg ? 16'h0002 : 16'h0001;
  // zero count wraps, so zero moves 64K
  assign count_dec_w = count_reg - step16_w;
  assign last_w      = (count_dec_w == 16'h0000);
  assign finished_w  = moved_reg && (count_reg == 16'h0000);
  assign go_w = mode_reg[MODE_STR] && !finished_w && budget_ok_w && !sw_rst_w;

  // bus answers and channel events
  // the berr input carries only the watchdog error
  assign ack_ok_w  = dma_req && dma_ack && !dma_berr;
  assign berr_w    = dma_req && dma_berr && !sw_rst_w;
  assign bes_ev_w  = (state_reg == ST_READ) && berr_w;
  assign bed_ev_w  = (state_reg == ST_WRITE) && berr_w;
  assign rd_done_w = (state_reg == ST_READ) && ack_ok_w && !sw_rst_w;
  assign wr_done_w = (state_reg == ST_WRITE) && ack_ok_w && !sw_rst_w;
  assign done_ev_w = wr_done_w && last_w;
  assign str_clr_w = done_ev_w || bes_ev_w || bed_ev_w;

  // sequencer: idle, read operand, write operand
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // a cleared start bit holds the channel here
        if (go_w) begin
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        if (berr_w) begin
          state_next = ST_IDLE;
        end else if (ack_ok_w) begin
          state_next = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (berr_w || ack_ok_w) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // software reset abandons the bus cycle
    if (sw_rst_w) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // 8-cycle window of bus use; overrun past the share carries on as debt, so long
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_reg  <= 3'h0;
      used_reg <= 8'h00;
    end else begin
      win_reg  <= win_reg + 3'h1;
      used_reg <= (win_reg != WIN_LAST) ? used_reg + 8'(dma_req) :
        (used_reg + 8'(dma_req) > 8'(allow_w)) ? used_reg + 8'(dma_req) - 8'(allow_w) : 8'h00;
    end
  end

  // channel_mode: a software write beats the automatic start clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= MODE_RESET;
    end else if (sw_rst_w) begin
      // reset bit clears the whole mode
      mode_reg <= MODE_RESET;
    end else if (wr_mode_w) begin
      mode_reg <= hwdata[15:0] & MODE_WMASK;
    end else if (str_clr_w) begin
      // start drops when finished or failed
      mode_reg[MODE_STR] <= 1'b0;
    end
  end

  // status: write one to clear, a new event wins over the clear
  // flags ignore both irq enables
  // done on a clean final operand
  assign set_w = {5'h00, bed_ev_w, bes_ev_w, done_ev_w};
  assign clr_w = wr_stat_w ? hwdata[7:0] : 8'h00;
  assign status_next = sw_rst_w ? STAT_RESET : ((status_reg & ~clr_w) | set_w);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= STAT_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // pointers, count and function code; software writes take priority
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_reg   <= 24'h000000;
      dst_reg   <= 24'h000000;
      fc_reg    <= 8'h00;
      count_reg <= 16'h0000;
      moved_reg <= 1'b0;
    end else begin
      // only the low 24 bits are kept
      if (wr_src_w) begin
        src_reg <= hwdata[23:0];
      end else if (rd_done_w && mode_reg[MODE_SOURCE_INCREMENT]) begin
        src_reg <= src_reg + step24_w;
      end
      if (wr_dst_w) begin
        dst_reg <= hwdata[23:0];
      end else if (wr_done_w && mode_reg[MODE_DESTINATION_INCREMENT]) begin
        dst_reg <= dst_reg + step24_w;
      end
      // software must load this before starting
      if (wr_fc_w) begin
        fc_reg <= hwdata[7:0];
      end
      if (wr_count_w) begin
        count_reg <= hwdata[15:0];
        moved_reg <= 1'b0;
      end else if (wr_done_w) begin
        count_reg <= count_dec_w;
        moved_reg <= 1'b1;
      end
    end
  end

  // bus cycle address, size and data, latched when a read or a write phase begins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 24'h000000;
      word_reg <= 1'b0;
      data_reg <= 16'h0000;
    end else if (state_reg == ST_IDLE && state_next == ST_READ) begin
      addr_reg <= src_reg;
      word_reg <= op_word_w;
    end else if (rd_done_w) begin
      addr_reg <= dst_reg;
      data_reg <= word_reg ? dma_rdata : {8'h00, dma_rdata[7:0]};
    end
  end

  // channel bus outputs; byte operands ride in the low lane
  // function code lines follow the register
  assign dma_req   = (state_reg != ST_IDLE);
  assign dma_write = (state_reg == ST_WRITE);
  assign dma_word  = word_reg;
  assign dma_addr  = addr_reg;
  assign dma_fc    = fc_reg[2:0];
  assign dma_wdata = data_reg;

  // request to the interrupt controller, a level until flags clear
  // normal request needs its enable
  assign irq = (mode_reg[MODE_NORMAL_IRQ_ENABLE] && status_reg[STAT_DONE]) ||
               (mode_reg[MODE_ERROR_IRQ_ENABLE] && (status_reg[STAT_BES] || status_reg[STAT_BED]));

  // checks on the channel's own behaviour
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  mode_rsvd_a: assert property (
    !mode_reg[MODE_RSVD] && !mode_reg[MODE_RST])
    else $error("reserved or reset mode bit reads one");

  done_irq_a: assert property (
    done_ev_w && !sw_rst_w ##1 mode_reg[MODE_NORMAL_IRQ_ENABLE] |-> irq)
    else $error("done with enable gave no irq");

  src_err_a: assert property (
    bes_ev_w |=> status_reg[STAT_BES] && state_reg == ST_IDLE)
    else $error("source error not recorded");

  flag_indep_a: assert property (
    bed_ev_w && !mode_reg[MODE_ERROR_IRQ_ENABLE] && !mode_reg[MODE_NORMAL_IRQ_ENABLE] && !wr_mode_w
    |=> status_reg[STAT_BED] && !irq)
    else $error("destination flag depends on enable");

  rate_cap_a: assert property (
    state_reg == ST_IDLE && state_next == ST_READ && request_generation_w == REQUEST_GENERATION_LIMITED
    |-> used_reg < 8'(allow_w))
    else $error("started beyond burst share");

  src_inc_a: assert property (
    rd_done_w && mode_reg[MODE_SOURCE_INCREMENT] && !wr_src_w
    |=> src_reg == $past(src_reg) + $past(step24_w))
    else $error("source pointer did not step");

  dst_hold_a: assert property (
    !mode_reg[MODE_DESTINATION_INCREMENT] && !wr_dst_w |=> dst_reg == $past(dst_reg))
    else $error("destination pointer moved while held");

  rst_clear_a: assert property (
    sw_rst_w |=> mode_reg == MODE_RESET && status_reg == STAT_RESET && !dma_req)
    else $error("software reset left state behind");

  halt_idle_a: assert property (
    state_reg == ST_IDLE && !mode_reg[MODE_STR] |=> state_reg == ST_IDLE)
    else $error("channel left idle while stopped");

  str_auto_a: assert property (
    done_ev_w && !wr_mode_w |=> !mode_reg[MODE_STR] ##1 state_reg == ST_IDLE)
    else $error("start bit not cleared at finish");

  fc_drive_a: assert property (
    dma_req |-> dma_fc == fc_reg[2:0])
    else $error("function code lines wrong");

  count_dec_a: assert property (
    wr_done_w && !wr_count_w |=> count_reg == $past(count_dec_w))
    else $error("count did not drop by size");

  done_seen_c: cover property (done_ev_w);
  src_err_c: cover property (bes_ev_w);
  dst_err_c: cover property (bed_ev_w);
  word_op_c: cover property (state_reg == ST_READ && word_reg ##[1:20] wr_done_w);

endmodule

/* test/gdc_mem_model.sv */
// gdc_mem_model: behavioural memory at the far side of the channel bus.
// assumes one request at a time, held by the channel until ack or berr.
`timescale 1ns/1ps
module gdc_mem_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        dma_req,
  input  wire logic        dma_write,
  input  wire logic        dma_word,
  input  wire logic [23:0] dma_addr,
  input  wire logic [2:0]  dma_fc,
  input  wire logic [15:0] dma_wdata,
  input  wire logic [3:0]  lat,
  input  wire logic        berr_rd,
  input  wire logic        berr_wr,
  output logic [15:0]      dma_rdata,
  output logic             dma_ack,
  output logic             dma_berr,
  output logic [2:0]       last_fc,
  output logic [15:0]      wr_cnt
);
  logic [7:0]  mem [256];
  logic [3:0]  wait_cnt;
  logic [15:0] rd_val;
  logic [7:0]  a;
  logic        fault;

  // only the low address byte is decoded; the rest aliases
  assign a = dma_addr[7:0];
  assign fault = dma_write ? berr_wr : berr_rd;
  // data stands only with the ack pulse, inverted otherwise so a late sample shows
  assign dma_rdata = dma_ack ? rd_val : ~rd_val;

  // answer after lat waiting cycles; reset preloads a known pattern, one driver only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 256; i++) mem[i] <= 8'(i) ^ 8'h5a;
      dma_ack  <= 1'b0;
      dma_berr <= 1'b0;
      wait_cnt <= 4'h0;
      rd_val   <= 16'h0;
      wr_cnt   <= 16'h0;
      last_fc  <= 3'h0;
    end else if (dma_req && !dma_ack && !dma_berr) begin
      last_fc  <= dma_fc;
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt >= lat) begin
        wait_cnt <= 4'h0;
        dma_berr <= fault;
        dma_ack  <= !fault;
        if (!fault && dma_write) begin
          wr_cnt <= wr_cnt + 16'h1;
          if (dma_word) begin
            mem[a]        <= dma_wdata[15:8];
            mem[a + 8'h1] <= dma_wdata[7:0];
          end else begin
            mem[a] <= dma_wdata[7:0];
          end
        end
        rd_val <= dma_word ? {mem[a], mem[a + 8'h1]} : {~mem[a], mem[a]};
      end
    end else begin
      dma_ack  <= 1'b0;
      dma_berr <= 1'b0;
      wait_cnt <= 4'h0;
    end
  end
endmodule

/* test/testbench.sv */
// testbench: register-level tests of the dma channel over ahb-lite.
// assumes gdc_mem_model on the channel bus; checks sit inside the design.
`timescale 1ns/1ps
module testbench import gdc_pkg::*;;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [3:0]  lat = 4'h0;
  logic        berr_rd = 1'b0;
  logic        berr_wr = 1'b0;
  logic        hreadyout, hresp, dma_req, dma_write, dma_word, dma_ack, dma_berr, irq;
  logic [31:0] hrdata, v, m;
  logic [23:0] dma_addr;
  logic [2:0]  dma_fc, last_fc;
  logic [15:0] dma_wdata, dma_rdata, wr_cnt;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          k, b, b0;
  int          dur [5];
  time         t;

  gdc_channel DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dma_req(dma_req),
    .dma_write(dma_write), .dma_word(dma_word), .dma_addr(dma_addr), .dma_fc(dma_fc),
    .dma_wdata(dma_wdata), .dma_rdata(dma_rdata), .dma_ack(dma_ack),
    .dma_berr(dma_berr), .irq(irq));
  gdc_mem_model mdl (.hclk(hclk), .hresetn(hresetn), .dma_req(dma_req),
    .dma_write(dma_write), .dma_word(dma_word), .dma_addr(dma_addr), .dma_fc(dma_fc),
    .dma_wdata(dma_wdata), .lat(lat), .berr_rd(berr_rd), .berr_wr(berr_wr),
    .dma_rdata(dma_rdata), .dma_ack(dma_ack), .dma_berr(dma_berr),
    .last_fc(last_fc), .wr_cnt(wr_cnt));

  // 25 mhz clock and an 8-cycle reset
  initial begin
    forever #20 hclk = ~hclk;
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
  end

  task automatic end_sim;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // a hang anywhere counts as a mismatch
  initial begin
    repeat (60000) @(posedge hclk);
    error_cnt++;
    end_sim();
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // one single transfer; trailing idle edge so a read never trails a write
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
    @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, v);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string msg);
    ahb(1'b0, a, 32'h0, v);
    chk(v, exp, msg);
  endtask

  // only request codes 00 and 01
  function automatic logic [31:0] md(input logic rq, input logic si, input logic di,
      input logic [1:0] sz, input logic [1:0] bt, input logic ie, input logic ine);
    return {18'h0, ine, ie, 1'b0, rq, si, di, sz, sz, bt, 2'b00};
  endfunction
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction

  task automatic arm(input logic [23:0] s, input logic [23:0] d, input logic [15:0] n,
                     input logic [31:0] mo);
    wr(ADDR_STAT, 32'hff);
    wr(ADDR_SRC, {8'h0, s});
    wr(ADDR_DST, {8'h0, d});
    wr(ADDR_COUNT, {16'h0, n});
    wr(ADDR_MODE, mo | 32'h1);
  endtask
  task automatic wait_stop;
    k = 0;
    v = 32'h1;
    while (v[0] === 1'b1 && k < 4000) begin
      ahb(1'b0, ADDR_MODE, 32'h0, v);
      k++;
    end
    chk({31'h0, v[0]}, 32'h0, "start stuck");
  endtask
  task automatic run(input logic [23:0] s, input logic [23:0] d, input logic [15:0] n,
                     input logic [31:0] mo);
    arm(s, d, n, mo);
    wait_stop();
  endtask
  task automatic mchk(input logic [7:0] s, input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++) chk(32'(mdl.mem[d + 8'(i)]), 32'(pat(s + 8'(i))), "copy");
  endtask

  initial begin
    @(posedge hresetn);
    @(posedge hclk);
    for (int i = 0; i < 6; i++) rc(8'(4 * i), 32'h0, "reset value");
    chk({31'h0, hresp}, 32'h0, "hresp okay");
    wr(ADDR_MODE, 32'h0000_f3a8);
    rc(ADDR_MODE, 32'h0000_73a8, "mode rw");
    wr(ADDR_SRC, 32'hffff_fffe);
    rc(ADDR_SRC, 32'h00ff_fffe, "src rw");
    wr(ADDR_DST, 32'h1234_5678);
    rc(ADDR_DST, 32'h0034_5678, "dst rw");
    wr(ADDR_COUNT, 32'h0001_ffff);
    rc(ADDR_COUNT, 32'h0000_ffff, "count rw");
    wr(8'h18, 32'hffff_ffff);
    rc(8'h18, 32'h0, "unmapped");
    wr(ADDR_FC, 32'h0000_00a5);
    rc(ADDR_FC, 32'h0000_00a5, "fc rw");
    // byte copy at full rate with normal irq enabled
    run(24'h10, 24'h40, 16'd8, md(1'b1, 1'b1, 1'b1, SIZE_BYTE, 2'h0, 1'b0, 1'b1));
    mchk(8'h10, 8'h40, 8);
    rc(ADDR_STAT, 32'h1, "done");
    chk({31'h0, irq}, 32'h1, "irq done");
    rc(ADDR_SRC, 32'h18, "src step");
    rc(ADDR_DST, 32'h48, "dst step");
    rc(ADDR_COUNT, 32'h0, "count end");
    chk({29'h0, last_fc}, 32'h5, "fc lines");
    wr(ADDR_STAT, 32'h1);
    rc(ADDR_STAT, 32'h0, "status clear");
    chk({31'h0, irq}, 32'h0, "irq drop");
    // word copy, slow slave, irq masked
    lat <= 4'h2;
    b = wr_cnt;
    run(24'h20, 24'h60, 16'd6, md(1'b1, 1'b1, 1'b1, SIZE_WORD, 2'h0, 1'b0, 1'b0));
    mchk(8'h20, 8'h60, 6);
    chk(32'(wr_cnt - b), 32'h3, "word ops");
    rc(ADDR_SRC, 32'h26, "src word");
    rc(ADDR_DST, 32'h66, "dst word");
    rc(ADDR_STAT, 32'h1, "done masked");
    chk({31'h0, irq}, 32'h0, "irq masked");
    // pointers held
    run(24'h30, 24'h70, 16'd3, md(1'b1, 1'b0, 1'b0, SIZE_BYTE, 2'h0, 1'b0, 1'b0));
    rc(ADDR_SRC, 32'h30, "src held");
    rc(ADDR_DST, 32'h70, "dst held");
    mchk(8'h30, 8'h70, 1);
    chk(32'(mdl.mem[8'h71]), 32'(pat(8'h71)), "dst untouched");
    // read error with irq, then write error without
    for (int e = 0; e < 2; e++) begin
      berr_rd <= (e == 0);
      berr_wr <= (e == 1);
      run(24'h10, 24'h80, 16'd4, md(1'b1, 1'b1, 1'b1, SIZE_BYTE, 2'h0, e == 0, 1'b0));
      rc(ADDR_STAT, 32'(2 << e), "error flag");
      chk({31'h0, irq}, 32'(e == 0), "error irq");
      chk(32'(mdl.mem[8'h80]), 32'(pat(8'h80)), "no write");
    end
    berr_rd <= 1'b0;
    berr_wr <= 1'b0;
    // stop in mid run, then resume
    lat <= 4'h3;
    m = md(1'b1, 1'b1, 1'b1, SIZE_BYTE, 2'h0, 1'b0, 1'b0);
    b0 = wr_cnt;
    arm(24'h0, 24'h90, 16'd16, m);
    repeat (20) @(posedge hclk);
    wr(ADDR_MODE, m);
    repeat (16) @(posedge hclk);
    b = wr_cnt;
    repeat (20) @(posedge hclk);
    chk(32'(wr_cnt - b), 32'h0, "halted");
    chk({31'h0, (b - b0) < 16}, 32'h1, "mid run");
    rc(ADDR_COUNT, 32'(16 - (b - b0)), "count kept");
    wr(ADDR_MODE, m | 32'h1);
    wait_stop();
    mchk(8'h0, 8'h90, 16);
    // software reset in mid run
    arm(24'h0, 24'hb0, 16'd16, m);
    repeat (15) @(posedge hclk);
    wr(ADDR_MODE, 32'h2);
    b = wr_cnt;
    rc(ADDR_MODE, 32'h0, "rst mode");
    rc(ADDR_STAT, 32'h0, "rst status");
    chk({31'h0, dma_req}, 32'h0, "rst idle");
    chk(32'(wr_cnt - b), 32'h0, "rst stop");
    // count zero wraps to 65535 and runs on, not done
    lat <= 4'h0;
    b = wr_cnt;
    arm(24'h10, 24'hc0, 16'h0, md(1'b1, 1'b0, 1'b0, SIZE_BYTE, 2'h0, 1'b0, 1'b0));
    repeat (100) @(posedge hclk);
    wr(ADDR_MODE, 32'h0);
    repeat (16) @(posedge hclk);
    rc(ADDR_COUNT, 32'(16'(b - wr_cnt)), "count wraps");
    rc(ADDR_STAT, 32'h0, "not done");
    // full rate against every burst share
    for (int r = 0; r < 5; r++) begin
      t = $time;
      run(24'h0, 24'hd0, 16'd12, md(r == 0, 1'b1, 1'b1, SIZE_BYTE, 2'(r - 1), 1'b0, 1'b0));
      dur[r] = int'(($time - t) / 40);
      mchk(8'h0, 8'hd0, 12);
    end
    chk({31'h0, dur[2] > dur[0]}, 32'h1, "half share slower");
    chk({31'h0, dur[4] > dur[0]}, 32'h1, "eighth share slower");
    chk({31'h0, dur[4] > dur[2]}, 32'h1, "eighth below half");
    end_sim();
  end
endmodule
